/* pkg/trig_xpoint_pkg.sv */
// types used by the trigger crosspoint; its bench does not import them
// assumes nothing beyond a systemverilog compiler
package trig_xpoint_pkg;

    // ============================================================
    // bus answer sequencer, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

    typedef logic [3:0] pin_field_t;

endpackage : trig_xpoint_pkg

/* pkg/trig_xpoint_regs.svh */
// register map, field positions and reset values of the trigger crosspoint
// assumes byte addressing on a 32-bit avalon slave, one register per word
`ifndef TRIG_XPOINT_REGS_SVH
`define TRIG_XPOINT_REGS_SVH

// ============================================================
// register offsets (byte addresses)
`define REG_SHIFT_OFS       8'h00
`define REG_STROBE_OFS      8'h04
`define REG_CTRL_OFS        8'h08
`define REG_STATUS_OFS      8'h0C
`define REG_UPD_CLEAR_OFS   8'h10
`define REG_ROUTE_LO_OFS    8'h14
`define REG_ROUTE_HI_OFS    8'h18
`define REG_DAC0_OFS        8'h1C
`define REG_DAC1_OFS        8'h20

// ============================================================
// control register fields
`define CTRL_PIN2_DRV_BIT   0
`define CTRL_PIN2_RCV_BIT   1
`define CTRL_PIN4_DRV_BIT   2
`define CTRL_PIN4_RCV_BIT   3
`define CTRL_WAVEFORM_GEN_ENABLE_BIT       4
`define CTRL_IRQ_EN_BIT     5
`define CTRL_DMA_EN_BIT     6
`define CTRL_MODE_LSB       7
`define CTRL_WIDTH          10
`define CTRL_RESET          10'h000

// ============================================================
// status register fields
`define STAT_PENDING_BIT    0
`define STAT_OVERRUN_BIT    1

// ============================================================
// routing pattern layout
`define ROUTE_WIDTH         56
`define ROUTE_HALF          28
`define ROUTE_RESET         56'h00000000000000
`define FIELD_OE_BIT        0
`define FIELD_SEL_LSB       1
`define PIN_COUNT           7
`define DAC_WIDTH           12
`define DAC_RESET           12'h000

`endif

/* testbench/tb.sv */
// self-checking bench for the trigger crosspoint
// assumes the pin levels are resolved here and by the partner model
`timescale 1ns/1ps
`include "trig_xpoint_regs.svh"

module tb;
    // ============================================================
    // stimulus and observed signals
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic        waitreq, gate, trig, irq, dreq;
    logic [6:0]  a_src = 7'h7F;
    logic [6:0]  far_en = 7'h08;
    logic [6:0]  far_val = 7'h00;
    logic [6:0]  a_out, a_oe, b_in, b_out, b_oe;
    logic        c2 = 1'b1;
    logic        c5 = 1'b1;
    logic        ext_n = 1'b1;
    logic        dack = 1'b0;
    logic [11:0] dac0, dac1;
    logic [11:0] ddata = 12'h000;
    int          failures = 0;
    int          checked = 0;
    // board pins: the device's drive wins, else the local signal
    wire logic [6:0] a_in = (a_oe & a_out) | (~a_oe & a_src);

    always #5 clk = ~clk;

    trig_xpoint dut (.CLK_SYS(clk), .RESET(rst), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .A_IN(a_in), .A_OUT(a_out),
        .A_OE(a_oe), .B_IN(b_in), .B_OUT(b_out), .B_OE(b_oe),
        .COUNTER2_OUTPUT(c2), .COUNTER5_OUTPUT(c5), .EXT_UPDATE_IN_N(ext_n),
        .COUNTER1_GATE_IN(gate), .UPDATE_TRIGGER_N(trig), .DAC0_OUT(dac0),
        .DAC1_OUT(dac1), .IRQ(irq), .DMA_REQ(dreq), .DMA_ACK(dack),
        .DMA_DATA(ddata));
    trig_partner far (.clk(clk), .b_out(b_out), .b_oe(b_oe),
        .far_en(far_en), .far_val(far_val), .line(b_in));

    // ============================================================
    // shared tasks
    task automatic stop_test;
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (waitreq !== 1'b0) begin
            failures++;
            $display("[FAIL] %0t bus timeout", $time);
            stop_test();
        end
    endtask : bus

    // pin inputs pass a synchroniser, so allow its latency
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask : settle

    task automatic pulse;
        @(posedge clk);
        ext_n <= 1'b0;
        settle();
        ext_n <= 1'b1;
        settle();
    endtask : pulse

    // ============================================================
    // scenarios
    task automatic t_route;
        logic [55:0] pat;
        pat = 56'h000000700B0000;
        for (int i = 0; i < 56; i++)
            bus(1'b1, `REG_SHIFT_OFS, {31'h7FFFFFFF, pat[i]});
        settle();
        chk(b_oe, 7'h00);
        bus(1'b1, `REG_STROBE_OFS, 32'h0);
        settle();
        chk({a_oe, b_oe}, {7'h01, 7'h10});
        bus(1'b0, `REG_ROUTE_LO_OFS, 32'h0);
        chk(q, 32'h000B0000);
        bus(1'b0, `REG_ROUTE_HI_OFS, 32'h0);
        chk(q, 32'h00000007);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            a_src[5] <= v[0];
            far_val[3] <= v[0];
            settle();
            chk({a_out[0], b_out[4]}, {v[0], v[0]});
        end
    endtask : t_route

    task automatic t_pins;
        logic e;
        for (int k = 0; k < 4; k++)
            for (int v = 0; v < 2; v++) begin
                bus(1'b1, `REG_CTRL_OFS, {28'h0, k[1:0], k[1:0]});
                @(posedge clk);
                {c2, c5} <= {v[0], v[0]};
                {a_src[2], a_src[4]} <= {!v[0], !v[0]};
                settle();
                e = k[1] ? (k[0] ? v[0] : !v[0]) : 1'b1;
                chk({gate, trig}, {e, e});
                chk({a_oe[4], a_oe[2]}, {k[0], k[0]});
                if (k[0])
                    chk({a_out[4], a_out[2]}, {v[0], v[0]});
            end
    endtask : t_pins

    task automatic t_update;
        bus(1'b1, `REG_CTRL_OFS, 32'h0);
        bus(1'b1, `REG_UPD_CLEAR_OFS, 32'h0);
        bus(1'b1, `REG_CTRL_OFS, 32'hA0);
        bus(1'b1, `REG_CTRL_OFS, 32'hB0);
        bus(1'b1, `REG_DAC0_OFS, 32'h123);
        settle();
        chk(dac0, 12'h000);
        pulse();
        chk({dac0, irq}, {12'h123, 1'b1});
        bus(1'b1, `REG_DAC0_OFS, 32'h456);
        pulse();
        bus(1'b0, `REG_STATUS_OFS, 32'h0);
        chk({q, dac0}, {32'h3, 12'h456});
        bus(1'b1, `REG_UPD_CLEAR_OFS, 32'h0);
        settle();
        bus(1'b0, `REG_STATUS_OFS, 32'h0);
        chk({q, irq}, {32'h0, 1'b0});
        bus(1'b1, `REG_CTRL_OFS, 32'hD0);
        pulse();
        chk(dreq, 1'b1);
        @(posedge clk);
        ddata <= 12'hABC;
        dack <= 1'b1;
        @(posedge clk);
        dack <= 1'b0;
        settle();
        chk(dreq, 1'b0);
        pulse();
        chk({dac0, dac1}, {12'hABC, 12'h0});
    endtask : t_update

    // ============================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({a_oe, b_oe, gate, trig}, {14'h0, 2'b11});
        t_route();
        t_pins();
        t_update();
        stop_test();
    end
endmodule : tb

/* testbench/trig_partner.sv */
// other boards on the shared trigger lines, resolving each line's level
// assumes the bench commands which lines the far boards drive
`timescale 1ns/1ps

module trig_partner (
    // clock
    input wire logic       clk,
    // device side of the lines
    input wire logic [6:0] b_out,
    input wire logic [6:0] b_oe,
    // far boards' drive
    input wire logic [6:0] far_en,
    input wire logic [6:0] far_val,
    // resolved levels
    output logic     [6:0] line
);
    // ============================================================
    // undriven lines wander every cycle so a stale level never passes
    logic [6:0] drift_ff = 7'h55;
    always_ff @(posedge clk) begin
        drift_ff <= ~drift_ff;
    end
    assign line = (b_oe & b_out) | (~b_oe & far_en & far_val)
                | (~b_oe & ~far_en & drift_ff);
endmodule : trig_partner

/* testbench/trig_xpoint_properties.sv */
// checker for the crosspoint's bus answer, routing load and update service
// assumes it is bound to trig_xpoint and sees only that module's ports
`timescale 1ns/1ps
`include "trig_xpoint_regs.svh"

module trig_xpoint_properties (
    // clock and reset
    input wire logic                  CLK_SYS,
    input wire logic                  RESET,
    // avalon-mm slave
    input wire logic [7:0]            AVS_ADDRESS,
    input wire logic                  AVS_READ,
    input wire logic                  AVS_WRITE,
    input wire logic                  AVS_WAITREQUEST,
    // switch pins and update service
    input wire logic [6:0]            A_OE,
    input wire logic [6:0]            B_OE,
    input wire logic                  UPDATE_TRIGGER_N,
    input wire logic [`DAC_WIDTH-1:0] DAC0_OUT,
    input wire logic                  IRQ,
    input wire logic                  DMA_REQ,
    input wire logic                  DMA_ACK
);
    // ============================================================
    // helpers: write commits and a seen trigger fall
    wire logic wr_done  = AVS_WRITE && !AVS_WAITREQUEST;
    wire logic clr_done = wr_done && AVS_ADDRESS == `REG_UPD_CLEAR_OFS;
    wire logic stb_done = wr_done && AVS_ADDRESS == `REG_STROBE_OFS;
    logic      trig_q_ff;
    wire logic fell_w   = trig_q_ff && !UPDATE_TRIGGER_N;
    // last trigger level, idle high like the port
    always_ff @(posedge CLK_SYS) begin
        trig_q_ff <= RESET ? 1'b1 : UPDATE_TRIGGER_N;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // ============================================================
    // properties
    sequence bus_req;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    wait_answer_a: assert property (bus_req |=> !AVS_WAITREQUEST)
        else $error("bus request not answered after one wait cycle");
    wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    wait_cause_a: assert property (
        !AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
        else $error("waitrequest low without a request");
    oe_reset_a: assert property (
        $fell(RESET) |-> A_OE == 7'h00 && B_OE == 7'h00)
        else $error("pin enables not clear after reset");
    route_strobe_a: assert property (
        $changed(B_OE) |-> $past(stb_done, 1) || $past(stb_done, 2))
        else $error("bus pin enables moved without a strobe");
    irq_clear_a: assert property (
        $fell(IRQ) |-> $past(clr_done, 1))
        else $error("interrupt dropped without a clear write");
    dac_trigger_a: assert property ($changed(DAC0_OUT) |->
        $past(fell_w, 1) || $past(fell_w, 2) || $past(fell_w, 3))
        else $error("converter output moved without a trigger fall");
    dma_ack_a: assert property (DMA_REQ && DMA_ACK |-> ##2 !DMA_REQ)
        else $error("dma request not withdrawn after acknowledge");
endmodule : trig_xpoint_properties

bind trig_xpoint trig_xpoint_properties u_props (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .A_OE(A_OE), .B_OE(B_OE),
    .UPDATE_TRIGGER_N(UPDATE_TRIGGER_N), .DAC0_OUT(DAC0_OUT),
    .IRQ(IRQ), .DMA_REQ(DMA_REQ), .DMA_ACK(DMA_ACK)
);

/* verilog/sync3_agree.sv */
// three-stage synchroniser for pin levels
// assumes inputs are asynchronous; a change counts when stage 2 and 3 agree
`timescale 1ns/1ps

module sync3_agree #(
    parameter int          W    = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;

    // ============================================================
    // chain; stage 1 feeds only stage 2 to keep metastability contained
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff <= INIT;
            s2_ff <= INIT;
            s3_ff <= INIT;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // per bit, take the new level only when the last two stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            q_ff <= INIT;
        end else begin
            q_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
        end
    end

    assign q = q_ff;

endmodule : sync3_agree

/* verilog/trig_xpoint.sv */
// trigger crosspoint switch with converter-update pacing
// assumes board pins and counter outputs are asynchronous to CLK_SYS,
// the dma acknowledge is synchronous, and the bench resolves wire levels
//
// Overview of operation
// - pin4 drive puts counter5 on A4
// - waveform enable: update on trigger fall
// - written values apply at next fall
// - pending flag held until clear write or dma acknowledge
// - irq enable plus mode raises interrupt
// - dma enable plus mode requests dma
// - pin2 drive puts counter2 on A2
// - pin2 receive feeds counter1 gate
// - both pin2 bits: counter2 drives gate
// - pin4 drive bit controls A4 drive
// - pin4 receive feeds update trigger
// - both pin4 bits: counter5 drives trigger
// - board pins carry fixed signals
// - seven bus pins, one per line
// - any side pin reaches any other
// - 56-bit pattern shifted, then strobed
// - low half bus, high half board
// - seven 4-bit fields per half
// - select picks source, enable drives
// - only bit 0 shifts in
// - update while pending sets overrun
// - dma acknowledge clears pending flag
`timescale 1ns/1ps
`include "trig_xpoint_regs.svh"

module trig_xpoint
    import trig_xpoint_pkg::*;
(
    // clock and reset
    input  wire logic                    CLK_SYS,
    input  wire logic                    RESET,
    // avalon-mm slave
    input  wire logic [7:0]              AVS_ADDRESS,
    input  wire logic                    AVS_READ,
    input  wire logic                    AVS_WRITE,
    input  wire logic [31:0]             AVS_WRITEDATA,
    input  wire logic [3:0]              AVS_BYTEENABLE,
    output logic      [31:0]             AVS_READDATA,
    output logic                         AVS_WAITREQUEST,
    // board-side switch pins
    input  wire logic [6:0]              A_IN,
    output logic      [6:0]              A_OUT,
    output logic      [6:0]              A_OE,
    // bus-side switch pins, one per shared trigger line
    input  wire logic [6:0]              B_IN,
    output logic      [6:0]              B_OUT,
    output logic      [6:0]              B_OE,
    // counter chip and connector signals
    input  wire logic                    COUNTER2_OUTPUT,
    input  wire logic                    COUNTER5_OUTPUT,
    input  wire logic                    EXT_UPDATE_IN_N,
    output logic                         COUNTER1_GATE_IN,
    output logic                         UPDATE_TRIGGER_N,
    // converter outputs
    output logic      [`DAC_WIDTH-1:0]   DAC0_OUT,
    output logic      [`DAC_WIDTH-1:0]   DAC1_OUT,
    // host service
    output logic                         IRQ,
    output logic                         DMA_REQ,
    input  wire logic                    DMA_ACK,
    input  wire logic [`DAC_WIDTH-1:0]   DMA_DATA
);

    // ============================================================
    // declarations
    bus_state_e                 state_ff;
    logic                       waitreq_ff;
    logic [31:0]                rdata_ff;
    logic [31:0]                nxt_rdata;
    logic                       acc_wr;
    logic                       lane0;
    logic                       lane1;
    logic [`ROUTE_WIDTH-1:0]    shift_ff;
    logic [`ROUTE_WIDTH-1:0]    route_ff;
    logic [`CTRL_WIDTH-1:0]     ctrl_ff;
    logic                       pending_ff;
    logic                       overrun_ff;
    logic [`DAC_WIDTH-1:0]      hold0_ff;
    logic [`DAC_WIDTH-1:0]      hold1_ff;
    logic [`DAC_WIDTH-1:0]      dac0_ff;
    logic [`DAC_WIDTH-1:0]      dac1_ff;
    logic                       trig_ff;
    logic                       trig_prev_ff;
    logic                       gate_ff;
    logic                       irq_ff;
    logic                       dmareq_ff;
    logic [6:0]                 a_out_ff;
    logic [6:0]                 a_oe_ff;
    logic [6:0]                 b_out_ff;
    logic [6:0]                 b_oe_ff;
    logic [6:0]                 nxt_a_out;
    logic [6:0]                 nxt_a_oe;
    logic [6:0]                 nxt_b_out;
    logic [6:0]                 nxt_b_oe;
    logic [16:0]                sync_q;
    logic [6:0]                 a_lvl;
    logic [6:0]                 b_lvl;
    logic                       cnt2_lvl;
    logic                       cnt5_lvl;
    logic                       ext_upd_lvl;
    logic                       nxt_trig;
    logic                       nxt_gate;
    logic                       trig_fall;
    logic                       upd_clear;
    logic                       mode_on;
    logic                       pin2_drive_enable;
    logic                       pin2_receive_enable;
    logic                       pin4_drive_enable;
    logic                       pin4_receive_enable;
    logic                       waveform_gen_enable;
    logic                       irq_enable;
    logic                       dma_request_enable;

    // ============================================================
    // pin synchronisers; idle level of every line is high
    sync3_agree #(
        .W    (17),
        .INIT (17'h1FFFF)
    ) u_pin_sync (
        .clk (CLK_SYS),
        .rst (RESET),
        .d   ({EXT_UPDATE_IN_N, COUNTER5_OUTPUT, COUNTER2_OUTPUT,
               B_IN, A_IN}),
        .q   (sync_q)
    );

    assign a_lvl       = sync_q[6:0];
    assign b_lvl       = sync_q[13:7];
    assign cnt2_lvl    = sync_q[14];
    assign cnt5_lvl    = sync_q[15];
    assign ext_upd_lvl = sync_q[16];

    // control fields
    assign pin2_drive_enable   = ctrl_ff[`CTRL_PIN2_DRV_BIT];
    assign pin2_receive_enable = ctrl_ff[`CTRL_PIN2_RCV_BIT];
    assign pin4_drive_enable   = ctrl_ff[`CTRL_PIN4_DRV_BIT];
    assign pin4_receive_enable = ctrl_ff[`CTRL_PIN4_RCV_BIT];
    assign waveform_gen_enable = ctrl_ff[`CTRL_WAVEFORM_GEN_ENABLE_BIT];
    assign irq_enable          = ctrl_ff[`CTRL_IRQ_EN_BIT];
    assign dma_request_enable  = ctrl_ff[`CTRL_DMA_EN_BIT];
    assign mode_on = |ctrl_ff[`CTRL_MODE_LSB +: 3];

    // ============================================================
    // bus slave: one wait cycle, then the access commits
    assign acc_wr    = (state_ff == BUS_ACK) && AVS_WRITE;
    assign lane0     = AVS_BYTEENABLE[0];
    assign lane1     = AVS_BYTEENABLE[1];
    assign upd_clear = acc_wr && (AVS_ADDRESS == `REG_UPD_CLEAR_OFS);

    // read mux; unmapped addresses read as zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        case (AVS_ADDRESS)
            `REG_CTRL_OFS: begin
                nxt_rdata[`CTRL_WIDTH-1:0] = ctrl_ff;
            end
            `REG_STATUS_OFS: begin
                nxt_rdata[`STAT_PENDING_BIT] = pending_ff;
                nxt_rdata[`STAT_OVERRUN_BIT] = overrun_ff;
            end
            `REG_ROUTE_LO_OFS: begin
                nxt_rdata[`ROUTE_HALF-1:0] = route_ff[`ROUTE_HALF-1:0];
            end
            `REG_ROUTE_HI_OFS: begin
                nxt_rdata[`ROUTE_HALF-1:0] =
                    route_ff[`ROUTE_WIDTH-1:`ROUTE_HALF];
            end
            `REG_DAC0_OFS: begin
                nxt_rdata[`DAC_WIDTH-1:0] = dac0_ff;
            end
            `REG_DAC1_OFS: begin
                nxt_rdata[`DAC_WIDTH-1:0] = dac1_ff;
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    // answer sequencer; read data is captured the cycle before release
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_ff   <= BUS_IDLE;
            waitreq_ff <= 1'b1;
            rdata_ff   <= 32'h00000000;
        end else begin
            case (state_ff)
                BUS_IDLE: begin
                    if (AVS_READ || AVS_WRITE) begin
                        state_ff   <= BUS_ACK;
                        waitreq_ff <= 1'b0;
                        rdata_ff   <= nxt_rdata;
                    end
                end
                BUS_ACK: begin
                    state_ff   <= BUS_IDLE;
                    waitreq_ff <= 1'b1;
                end
                default: begin
                    state_ff   <= BUS_IDLE;
                    waitreq_ff <= 1'b1;
                end
            endcase
        end
    end

    // ============================================================
    // control register; the low lane holds all but the top mode bits
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ctrl_ff <= `CTRL_RESET;
        end else if (acc_wr && AVS_ADDRESS == `REG_CTRL_OFS) begin
            if (lane0) begin
                ctrl_ff[7:0] <= AVS_WRITEDATA[7:0];
            end
            if (lane1) begin
                ctrl_ff[9:8] <= AVS_WRITEDATA[9:8];
            end
        end
    end

    // ============================================================
    // routing pattern: shift stage and active stage
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            shift_ff <= `ROUTE_RESET;
        end else if (acc_wr && lane0 && AVS_ADDRESS == `REG_SHIFT_OFS) begin
            shift_ff <= {AVS_WRITEDATA[0], shift_ff[`ROUTE_WIDTH-1:1]};
        end
    end

    // the live routing copies the shift stage only on a strobe write, so a half-shifted
    // pattern cannot glitch the trigger lines
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            route_ff <= `ROUTE_RESET;
        end else if (acc_wr && AVS_ADDRESS == `REG_STROBE_OFS) begin
            route_ff <= shift_ff;
        end
    end

    // ============================================================
    // crosspoint fabric, one field per pin on each side
    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_pin
            pin_field_t a_fld;
            pin_field_t b_fld;
            logic [7:0] a_src;
            logic [7:0] b_src;
            logic       a_local;
            logic       a_local_en;
            assign a_fld = route_ff[`ROUTE_HALF + 4*gi +: 4];
            assign b_fld = route_ff[4*gi +: 4];
            // any pin selectable; code 7 selects idle high
            assign a_src = {1'b1, b_lvl};
            assign b_src = {1'b1, a_lvl};
            // A2 and A4 also carry counter outputs
            assign a_local_en = ((gi == 2) && pin2_drive_enable) ||
                                ((gi == 4) && pin4_drive_enable);
            assign a_local = (gi == 2) ? cnt2_lvl :
                             (gi == 4) ? cnt5_lvl : 1'b1;
            assign nxt_a_oe[gi]  = a_fld[`FIELD_OE_BIT] | a_local_en;
            assign nxt_a_out[gi] = a_fld[`FIELD_OE_BIT] ?
                a_src[a_fld[3:`FIELD_SEL_LSB]] : a_local;
            assign nxt_b_oe[gi]  = b_fld[`FIELD_OE_BIT];
            assign nxt_b_out[gi] = b_src[b_fld[3:`FIELD_SEL_LSB]];
        end
    endgenerate

    // pin drivers registered so every pin output comes from a flop
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            a_out_ff <= 7'h7F;
            a_oe_ff  <= 7'h00;
            b_out_ff <= 7'h7F;
            b_oe_ff  <= 7'h00;
        end else begin
            a_out_ff <= nxt_a_out;
            a_oe_ff  <= nxt_a_oe;
            b_out_ff <= nxt_b_out;
            b_oe_ff  <= nxt_b_oe;
        end
    end

    // ============================================================
    // receive steering for the dual-use pins
    always_comb begin
        if (!pin2_receive_enable) begin
            nxt_gate = 1'b1;
        end else if (pin2_drive_enable) begin
            nxt_gate = cnt2_lvl;
        end else begin
            nxt_gate = a_lvl[2];
        end
        if (!pin4_receive_enable) begin
            nxt_trig = ext_upd_lvl;
        end else if (pin4_drive_enable) begin
            nxt_trig = cnt5_lvl;
        end else begin
            nxt_trig = a_lvl[4];
        end
    end

    // steering registered; trig_prev gives the falling-edge detect
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            gate_ff      <= 1'b1;
            trig_ff      <= 1'b1;
            trig_prev_ff <= 1'b1;
        end else begin
            gate_ff      <= nxt_gate;
            trig_ff      <= nxt_trig;
            trig_prev_ff <= trig_ff;
        end
    end

    assign trig_fall = trig_prev_ff & ~trig_ff;

    // ============================================================
    // converter holding and output registers
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            hold0_ff <= `DAC_RESET;
            hold1_ff <= `DAC_RESET;
        end else begin
            if (acc_wr && lane0 && lane1 && AVS_ADDRESS == `REG_DAC0_OFS) begin
                hold0_ff <= AVS_WRITEDATA[`DAC_WIDTH-1:0];
            end else if (DMA_ACK && DMA_REQ) begin
                hold0_ff <= DMA_DATA;
            end
            if (acc_wr && lane0 && lane1 && AVS_ADDRESS == `REG_DAC1_OFS) begin
                hold1_ff <= AVS_WRITEDATA[`DAC_WIDTH-1:0];
            end
        end
    end

    // outputs move only on a trigger fall, never on the host write itself
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            dac0_ff <= `DAC_RESET;
            dac1_ff <= `DAC_RESET;
        end else if (trig_fall && waveform_gen_enable) begin
            dac0_ff <= hold0_ff;
            dac1_ff <= hold1_ff;
        end
    end

    // ============================================================
    // pending and overrun flags; a new fall wins over a clear
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pending_ff <= 1'b0;
        end else if (trig_fall) begin
            pending_ff <= 1'b1;
        end else if (upd_clear || (DMA_ACK && DMA_REQ)) begin
            pending_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            overrun_ff <= 1'b0;
        end else if (trig_fall && pending_ff) begin
            overrun_ff <= 1'b1;
        end else if (upd_clear) begin
            overrun_ff <= 1'b0;
        end
    end

    // ============================================================
    // service requests; both need a nonzero mode, per the set-up order
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            irq_ff    <= 1'b0;
            dmareq_ff <= 1'b0;
        end else begin
            irq_ff    <= irq_enable && mode_on && pending_ff &&
                         !upd_clear;
            dmareq_ff <= dma_request_enable && mode_on && pending_ff &&
                         !upd_clear && !(DMA_ACK && dmareq_ff);
        end
    end

    // ============================================================
    // outputs
    assign AVS_READDATA     = rdata_ff;
    assign AVS_WAITREQUEST  = waitreq_ff;
    assign A_OUT            = a_out_ff;
    assign A_OE             = a_oe_ff;
    assign B_OUT            = b_out_ff;
    assign B_OE             = b_oe_ff;
    assign COUNTER1_GATE_IN = gate_ff;
    assign UPDATE_TRIGGER_N = trig_ff;
    assign DAC0_OUT         = dac0_ff;
    assign DAC1_OUT         = dac1_ff;
    assign IRQ              = irq_ff;
    assign DMA_REQ          = dmareq_ff;

endmodule : trig_xpoint
